// ### design/irq_ctrl_consts.svh
// Constants for the prioritized interrupt controller
`ifndef IRQ_CTRL_CONSTS_SVH
`define IRQ_CTRL_CONSTS_SVH
// **********************
// Register indices (byte address is index times four)
// **********************
`define IDX_FLAGS_B 8'h97
`define IDX_EN_C 8'h9A
`define IDX_EN_A 8'hA8
`define IDX_PRIO_LO 8'hA9
`define IDX_EN_B 8'hB8
`define IDX_PRIO_HI 8'hB9
`define IDX_FLAGS_A 8'hC0
`define IDX_EVT_STAT 8'hD0
`define IDX_EVT_CLR 8'hD1
`define IDX_EVT_EN 8'hD2
`define IDX_INSERV 8'hD3
`define REG_RST 8'h00
// **********************
// Field positions and masks
// **********************
`define EN_A_GATE 7
`define EN_A_T2 5
`define EN_A_SER0 4
`define EN_A_T1 3
`define EN_A_EXT1 2
`define EN_A_T0 1
`define EN_A_EXT0 0
`define EN_B_T2RL 7
`define EN_C_CMP 2
`define EN_C_RTC 1
`define EN_C_SER1 0
`define FA_T2RL 7
`define FA_T2OV 6
`define FB_CMP 2
`define FB_RTC 1
// Flags A and enable B share one layout for these sources
`define FL_PWM 0
`define FL_SPI 1
`define FL_ADC 2
`define FL_KBI 3
`define FL_LVI 4
`define FL_IIC 5
`define EN_MASK 8'hBF
`define EN_C_MASK 8'h07
`define FB_MASK 8'h06
`define PRIO_MASK 8'h3F
`define EVT_TAKEN 0
`define EVT_NESTED 1
`define EVT_RETURN 2
`define EVT_MASK 8'h07
// **********************
// Sources in polling order
// **********************
`define NUM_SRC 15
`define SRC_EXT0 4'h0
`define SRC_SER1 4'h1
`define SRC_PWM 4'h2
`define SRC_T0 4'h3
`define SRC_RTC 4'h4
`define SRC_SPI 4'h5
`define SRC_EXT1 4'h6
`define SRC_CMP 4'h7
`define SRC_ADC 4'h8
`define SRC_T1 4'h9
`define SRC_KBI 4'hA
`define SRC_SER0 4'hB
`define SRC_LVI 4'hC
`define SRC_T2 4'hD
`define SRC_IIC 4'hE
// **********************
// Vectors and call timing
// **********************
`define VEC_EXT0 16'h0003
`define VEC_T0 16'h000B
`define VEC_EXT1 16'h0013
`define VEC_T1 16'h001B
`define VEC_SER0 16'h0023
`define VEC_T2 16'h002B
`define VEC_PWM 16'h0043
`define VEC_SPI 16'h004B
`define VEC_ADC 16'h0053
`define VEC_KBI 16'h005B
`define VEC_LVI 16'h0063
`define VEC_IIC 16'h006B
`define VEC_SER1 16'h0083
`define VEC_RTC 16'h008B
`define VEC_CMP 16'h0093
`define CALL_LAST 3'h5
`endif

// ### design/irq_ctrl_pkg.sv
// Types shared by the interrupt controller files
package irq_ctrl_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DETECT = 2'b01,
        ST_CALL = 2'b11
    } ctl_state_t;
    typedef logic [3:0] src_idx_t;
    typedef logic [1:0] prio_lvl_t;
endpackage

// ### design/arb_if.sv
// Request and winner signals between controller and arbiter
`timescale 1ns/100ps
`include "irq_ctrl_consts.svh"
interface arb_if;
    logic [`NUM_SRC-1:0] req;
    irq_ctrl_pkg::prio_lvl_t lvl [`NUM_SRC];
    logic win_valid;
    irq_ctrl_pkg::src_idx_t win_idx;
    irq_ctrl_pkg::prio_lvl_t win_lvl;
    modport ctl (output req, lvl, input win_valid, win_idx, win_lvl);
    modport arb (input req, lvl, output win_valid, win_idx, win_lvl);
endinterface

// ### design/irq_poll_arbiter.sv
// Level-then-polling-order arbiter over all request lines
`timescale 1ns/100ps
`include "irq_ctrl_consts.svh"
module irq_poll_arbiter (
    // Requests in, winner out
    arb_if.arb bus
);
    logic found;
    irq_ctrl_pkg::src_idx_t idx;
    irq_ctrl_pkg::prio_lvl_t lvl;

    // **********************
    // Resolver
    // **********************
    // lowest index wins a tie
    always_comb begin
        found = 1'b0;
        idx = 4'h0;
        lvl = 2'h0;
        // Walking downward with >= lets the earlier source take a tie
        for (int i = `NUM_SRC - 1; i >= 0; i--) begin
            if (bus.req[i] && (!found || bus.lvl[i] >= lvl)) begin
                found = 1'b1;
                idx = 4'(i);
                lvl = bus.lvl[i];
            end
        end
    end

    assign bus.win_valid = found;
    assign bus.win_idx = idx;
    assign bus.win_lvl = lvl;
endmodule

// ### design/irq_prio_ctrl.sv
// Prioritized interrupt controller with APB register access
//
// The APB interface to the registers was decided locally.
`timescale 1ns/100ps
`include "irq_ctrl_consts.svh"
module irq_prio_ctrl (
    // Clock, reset, enable
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    input wire logic ce_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [9:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Interrupt sources
    input wire logic pin_irq_a_in,
    input wire logic pin_irq_b_in,
    input wire logic timer0_req_in,
    input wire logic timer1_req_in,
    input wire logic serial_a_req_in,
    input wire logic serial_b_req_in,
    input wire logic [7:0] flag_a_set_in,
    input wire logic comparator_set_in,
    input wire logic clock_alarm_set_in,
    // CPU core
    input wire logic cpu_ack_in,
    input wire logic return_from_interrupt_in,
    output logic irq_req_out,
    output logic [15:0] vector_out,
    output logic call_active_out,
    output logic vector_enter_out,
    // Summary interrupt
    output logic irq_out
);
    // **********************
    // Declarations
    // **********************
    logic pin_a_q1_r, pin_a_q2_r, pin_b_q1_r, pin_b_q2_r;
    logic [7:0] en_a_r, en_b_r, en_c_r, prio_lo_r, prio_hi_r, flags_a_r, flags_b_r;
    logic [7:0] en_a_nxt, en_b_nxt, en_c_nxt, prio_lo_nxt, prio_hi_nxt;
    logic [7:0] flags_a_nxt, flags_b_nxt, evt_r, evt_nxt, evt_en_r, evt_en_nxt;
    logic [3:0] inserv_r, inserv_nxt;
    logic [2:0] cnt_r, cnt_nxt, top;
    logic [31:0] prdata_r, prdata_nxt;
    logic irq_line_r, irq_line_nxt, enter_r, enter_nxt;
    irq_ctrl_pkg::ctl_state_t st_r, st_nxt;
    irq_ctrl_pkg::src_idx_t idx_r, idx_nxt;
    irq_ctrl_pkg::prio_lvl_t lvl_r, lvl_nxt;
    logic [15:0] vec_r, vec_nxt;
    logic [7:0] addr_idx, rd_byte;
    logic wr, entering, allowed, gate;
    arb_if arb_bus ();

    irq_poll_arbiter u_arb (
        .bus(arb_bus)
    );

    // **********************
    // Helper functions
    // **********************
    function automatic logic [2:0] top_lvl(input logic [3:0] s);
        top_lvl = 3'h0;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                top_lvl = {1'b1, 2'(i)};
            end
        end
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        case (a)
            `IDX_FLAGS_B, `IDX_EN_C, `IDX_EN_A, `IDX_PRIO_LO, `IDX_EN_B,
            `IDX_PRIO_HI, `IDX_FLAGS_A, `IDX_EVT_STAT, `IDX_EVT_CLR,
            `IDX_EVT_EN, `IDX_INSERV: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction

    function automatic logic [2:0] grp_of(input irq_ctrl_pkg::src_idx_t s);
        unique case (s)
            `SRC_EXT0, `SRC_SER1, `SRC_PWM: grp_of = 3'h0;
            `SRC_T0, `SRC_RTC, `SRC_SPI: grp_of = 3'h1;
            `SRC_EXT1, `SRC_CMP, `SRC_ADC: grp_of = 3'h2;
            `SRC_T1, `SRC_KBI: grp_of = 3'h3;
            `SRC_SER0, `SRC_LVI: grp_of = 3'h4;
            `SRC_T2, `SRC_IIC: grp_of = 3'h5;
            default: grp_of = 3'h0;
        endcase
    endfunction

    function automatic logic [15:0] vector_of(input irq_ctrl_pkg::src_idx_t s);
        unique case (s)
            `SRC_EXT0: vector_of = `VEC_EXT0;
            `SRC_SER1: vector_of = `VEC_SER1;
            `SRC_PWM: vector_of = `VEC_PWM;
            `SRC_T0: vector_of = `VEC_T0;
            `SRC_RTC: vector_of = `VEC_RTC;
            `SRC_SPI: vector_of = `VEC_SPI;
            `SRC_EXT1: vector_of = `VEC_EXT1;
            `SRC_CMP: vector_of = `VEC_CMP;
            `SRC_ADC: vector_of = `VEC_ADC;
            `SRC_T1: vector_of = `VEC_T1;
            `SRC_KBI: vector_of = `VEC_KBI;
            `SRC_SER0: vector_of = `VEC_SER0;
            `SRC_LVI: vector_of = `VEC_LVI;
            `SRC_T2: vector_of = `VEC_T2;
            `SRC_IIC: vector_of = `VEC_IIC;
            default: vector_of = `VEC_EXT0;
        endcase
    endfunction

    // **********************
    // Pin synchronisers
    // **********************
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pin_a_q1_r <= 1'b0;
            pin_a_q2_r <= 1'b0;
            pin_b_q1_r <= 1'b0;
            pin_b_q2_r <= 1'b0;
        end else if (ce_in) begin
            pin_a_q1_r <= pin_irq_a_in;
            pin_a_q2_r <= pin_a_q1_r;
            pin_b_q1_r <= pin_irq_b_in;
            pin_b_q2_r <= pin_b_q1_r;
        end
    end

    // **********************
    // Request gating
    // **********************
    assign gate = en_a_r[`EN_A_GATE];
    always_comb begin
        arb_bus.req = '0;
        // flag and own enable per source
        arb_bus.req[`SRC_EXT0] = pin_a_q2_r & en_a_r[`EN_A_EXT0];
        arb_bus.req[`SRC_SER1] = serial_b_req_in & en_c_r[`EN_C_SER1];
        arb_bus.req[`SRC_PWM] = flags_a_r[`FL_PWM] & en_b_r[`FL_PWM];
        arb_bus.req[`SRC_T0] = timer0_req_in & en_a_r[`EN_A_T0];
        arb_bus.req[`SRC_RTC] = flags_b_r[`FB_RTC] & en_c_r[`EN_C_RTC];
        arb_bus.req[`SRC_SPI] = flags_a_r[`FL_SPI] & en_b_r[`FL_SPI];
        arb_bus.req[`SRC_EXT1] = pin_b_q2_r & en_a_r[`EN_A_EXT1];
        arb_bus.req[`SRC_CMP] = flags_b_r[`FB_CMP] & en_c_r[`EN_C_CMP];
        arb_bus.req[`SRC_ADC] = flags_a_r[`FL_ADC] & en_b_r[`FL_ADC];
        arb_bus.req[`SRC_T1] = timer1_req_in & en_a_r[`EN_A_T1];
        arb_bus.req[`SRC_KBI] = flags_a_r[`FL_KBI] & en_b_r[`FL_KBI];
        arb_bus.req[`SRC_SER0] = serial_a_req_in & en_a_r[`EN_A_SER0];
        arb_bus.req[`SRC_LVI] = flags_a_r[`FL_LVI] & en_b_r[`FL_LVI];
        // reload cause also needs its own enable
        arb_bus.req[`SRC_T2] = en_a_r[`EN_A_T2] & (flags_a_r[`FA_T2OV]
            | (flags_a_r[`FA_T2RL] & en_b_r[`EN_B_T2RL]));
        arb_bus.req[`SRC_IIC] = flags_a_r[`FL_IIC] & en_b_r[`FL_IIC];
        if (!gate) begin
            arb_bus.req = '0;
        end
    end

    // group level from both priority registers
    for (genvar g = 0; g < `NUM_SRC; g++) begin : g_lvl
        assign arb_bus.lvl[g] = {prio_hi_r[grp_of(4'(g))], prio_lo_r[grp_of(4'(g))]};
    end

    // **********************
    // Sequencer
    // **********************
    assign top = top_lvl(inserv_r);
    // strictly higher than the running level
    assign allowed = arb_bus.win_valid && (!top[2] || arb_bus.win_lvl > top[1:0]);
    assign entering = (st_r == irq_ctrl_pkg::ST_CALL) && (cnt_r == `CALL_LAST);

    always_comb begin
        st_nxt = st_r;
        idx_nxt = idx_r;
        lvl_nxt = lvl_r;
        vec_nxt = vec_r;
        cnt_nxt = cnt_r;
        enter_nxt = 1'b0;
        inserv_nxt = inserv_r;
        if (return_from_interrupt_in && top[2]) begin
            inserv_nxt[top[1:0]] = 1'b0;
        end
        unique case (st_r)
            irq_ctrl_pkg::ST_IDLE: begin
                if (allowed) begin
                    st_nxt = irq_ctrl_pkg::ST_DETECT;
                    idx_nxt = arb_bus.win_idx;
                    lvl_nxt = arb_bus.win_lvl;
                    vec_nxt = vector_of(arb_bus.win_idx);
                end
            end
            irq_ctrl_pkg::ST_DETECT: begin
                // Core acks what it saw, so no re-latch on the ack cycle
                if (cpu_ack_in) begin
                    st_nxt = irq_ctrl_pkg::ST_CALL;
                    cnt_nxt = 3'h0;
                end else if (!allowed) begin
                    st_nxt = irq_ctrl_pkg::ST_IDLE;
                end else begin
                    idx_nxt = arb_bus.win_idx;
                    lvl_nxt = arb_bus.win_lvl;
                    vec_nxt = vector_of(arb_bus.win_idx);
                end
            end
            irq_ctrl_pkg::ST_CALL: begin
                // six cycles of forced call to the vector
                cnt_nxt = cnt_r + 3'h1;
                if (entering) begin
                    st_nxt = irq_ctrl_pkg::ST_IDLE;
                    enter_nxt = 1'b1;
                    inserv_nxt[lvl_r] = 1'b1;
                end
            end
            default: st_nxt = irq_ctrl_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_r <= irq_ctrl_pkg::ST_IDLE;
            idx_r <= 4'h0;
            lvl_r <= 2'h0;
            vec_r <= 16'h0000;
            cnt_r <= 3'h0;
            enter_r <= 1'b0;
            inserv_r <= 4'h0;
        end else if (ce_in) begin
            st_r <= st_nxt;
            idx_r <= idx_nxt;
            lvl_r <= lvl_nxt;
            vec_r <= vec_nxt;
            cnt_r <= cnt_nxt;
            enter_r <= enter_nxt;
            inserv_r <= inserv_nxt;
        end
    end

    // **********************
    // Register file
    // **********************
    assign addr_idx = paddr_in[9:2];
    assign wr = psel_in && penable_in && pwrite_in && ce_in && is_mapped(addr_idx);

    always_comb begin
        unique case (addr_idx)
            `IDX_FLAGS_B: rd_byte = flags_b_r;
            `IDX_EN_C: rd_byte = en_c_r;
            `IDX_EN_A: rd_byte = en_a_r;
            `IDX_PRIO_LO: rd_byte = prio_lo_r;
            `IDX_EN_B: rd_byte = en_b_r;
            `IDX_PRIO_HI: rd_byte = prio_hi_r;
            `IDX_FLAGS_A: rd_byte = flags_a_r;
            `IDX_EVT_STAT: rd_byte = evt_r;
            `IDX_EVT_EN: rd_byte = evt_en_r;
            `IDX_INSERV: rd_byte = {4'h0, inserv_r};
            default: rd_byte = 8'h00;
        endcase
    end

    always_comb begin
        en_a_nxt = en_a_r;
        en_b_nxt = en_b_r;
        en_c_nxt = en_c_r;
        prio_lo_nxt = prio_lo_r;
        prio_hi_nxt = prio_hi_r;
        flags_a_nxt = flags_a_r;
        flags_b_nxt = flags_b_r;
        evt_nxt = evt_r;
        evt_en_nxt = evt_en_r;
        prdata_nxt = prdata_r;
        if (psel_in && !penable_in) begin
            prdata_nxt = {24'h000000, rd_byte};
        end
        if (wr) begin
            unique case (addr_idx)
                `IDX_EN_A: en_a_nxt = pwdata_in[7:0] & `EN_MASK;
                `IDX_EN_B: en_b_nxt = pwdata_in[7:0] & `EN_MASK;
                `IDX_EN_C: en_c_nxt = pwdata_in[7:0] & `EN_C_MASK;
                `IDX_PRIO_LO: prio_lo_nxt = pwdata_in[7:0] & `PRIO_MASK;
                `IDX_PRIO_HI: prio_hi_nxt = pwdata_in[7:0] & `PRIO_MASK;
                `IDX_FLAGS_A: flags_a_nxt = pwdata_in[7:0];
                // software may clear RTC and comparator flags
                `IDX_FLAGS_B: flags_b_nxt = pwdata_in[7:0] & `FB_MASK;
                `IDX_EVT_CLR: evt_nxt = evt_r & ~pwdata_in[7:0];
                `IDX_EVT_EN: evt_en_nxt = pwdata_in[7:0] & `EVT_MASK;
                default: evt_en_nxt = evt_en_r;
            endcase
        end
        // vector entry clears the RTC or comparator flag
        if (entering && idx_r == `SRC_RTC) begin
            flags_b_nxt[`FB_RTC] = 1'b0;
        end
        if (entering && idx_r == `SRC_CMP) begin
            flags_b_nxt[`FB_CMP] = 1'b0;
        end
        // hardware set wins over any clear
        flags_a_nxt = flags_a_nxt | flag_a_set_in;
        flags_b_nxt[`FB_RTC] = flags_b_nxt[`FB_RTC] | clock_alarm_set_in;
        flags_b_nxt[`FB_CMP] = flags_b_nxt[`FB_CMP] | comparator_set_in;
        evt_nxt[`EVT_TAKEN] = evt_nxt[`EVT_TAKEN] | entering;
        evt_nxt[`EVT_NESTED] = evt_nxt[`EVT_NESTED] | (entering && top[2]);
        evt_nxt[`EVT_RETURN] = evt_nxt[`EVT_RETURN] | (return_from_interrupt_in && top[2]);
        irq_line_nxt = |(evt_nxt & evt_en_nxt);
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            // all nine registers clear on reset
            en_a_r <= `REG_RST;
            en_b_r <= `REG_RST;
            en_c_r <= `REG_RST;
            prio_lo_r <= `REG_RST;
            prio_hi_r <= `REG_RST;
            flags_a_r <= `REG_RST;
            flags_b_r <= `REG_RST;
            evt_r <= `REG_RST;
            evt_en_r <= `REG_RST;
            prdata_r <= 32'h00000000;
            irq_line_r <= 1'b0;
        end else if (ce_in) begin
            en_a_r <= en_a_nxt;
            en_b_r <= en_b_nxt;
            en_c_r <= en_c_nxt;
            prio_lo_r <= prio_lo_nxt;
            prio_hi_r <= prio_hi_nxt;
            flags_a_r <= flags_a_nxt;
            flags_b_r <= flags_b_nxt;
            evt_r <= evt_nxt;
            evt_en_r <= evt_en_nxt;
            prdata_r <= prdata_nxt;
            irq_line_r <= irq_line_nxt;
        end
    end

    // **********************
    // Outputs
    // **********************
    // Frozen block cannot take a transfer, so it stretches the access
    assign pready_out = ce_in;
    assign pslverr_out = psel_in && penable_in && !is_mapped(addr_idx);
    assign prdata_out = prdata_r;
    assign irq_req_out = (st_r == irq_ctrl_pkg::ST_DETECT);
    assign vector_out = vec_r;
    assign call_active_out = (st_r == irq_ctrl_pkg::ST_CALL);
    assign vector_enter_out = enter_r;
    assign irq_out = irq_line_r;

    // **********************
    // Assertions
    // **********************
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!arst_n_in);

    AST_GATE_BLOCKS: assert property (
        (st_r == irq_ctrl_pkg::ST_IDLE && !gate) |=> st_r == irq_ctrl_pkg::ST_IDLE)
        else $error("request taken while global gate closed");
    AST_EN_A_MASK: assert property (
        (timer0_req_in && !en_a_r[`EN_A_T0]) |-> !arb_bus.req[`SRC_T0])
        else $error("timer0 request passed while disabled");
    AST_EN_B_MASK: assert property (
        (flags_a_r[`FL_PWM] && gate && en_b_r[`FL_PWM]) |-> arb_bus.req[`SRC_PWM])
        else $error("enabled pwm flag raised no request");
    AST_FLAG_SET: assert property (
        (flag_a_set_in[`FL_ADC] && ce_in) |=> flags_a_r[`FL_ADC])
        else $error("flag not set by its condition");
    AST_T2_KEPT: assert property (
        (entering && ce_in && flags_a_r[`FA_T2OV] && !wr) |=> flags_a_r[`FA_T2OV])
        else $error("timer2 overflow flag cleared by hardware");
    AST_RTC_AUTOCLR: assert property (
        (entering && ce_in && idx_r == `SRC_RTC && !clock_alarm_set_in)
        |=> !flags_b_r[`FB_RTC])
        else $error("rtc flag survived vector entry");
    AST_SW_CLEAR: assert property (
        (wr && addr_idx == `IDX_FLAGS_B && !pwdata_in[`FB_CMP] && !comparator_set_in)
        |=> !flags_b_r[`FB_CMP])
        else $error("software could not clear comparator flag");
    AST_TIE_ORDER: assert property (
        arb_bus.req[`SRC_EXT0] |->
        (arb_bus.win_idx == `SRC_EXT0 || arb_bus.win_lvl > arb_bus.lvl[`SRC_EXT0]))
        else $error("polling order broken on tie");
    AST_PREEMPT: assert property (
        (irq_req_out && top[2]) |-> lvl_r > top[1:0])
        else $error("equal or lower level preempted");
    AST_RESPONSE: assert property (
        (irq_req_out && cpu_ack_in && ce_in) ##1 ce_in [*6] |=> vector_enter_out)
        else $error("forced call did not last six cycles");
    AST_VECTOR: assert property (
        $rose(vector_enter_out) |-> vector_out == vector_of(idx_r))
        else $error("wrong vector on entry");

    COV_NESTED: cover property (entering && top[2]);
    COV_RTC_ENTRY: cover property (entering && idx_r == `SRC_RTC);
    COV_RETURN: cover property (return_from_interrupt_in && top[2]);
    COV_TIE: cover property (arb_bus.req[`SRC_EXT0] && arb_bus.req[`SRC_IIC]);
endmodule

// ### bench/cpu_core_model.sv
// Core model: acks presented requests, returns on command
`timescale 1ns/100ps
module cpu_core_model (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    // Controller side
    input wire logic irq_req_in,
    output logic cpu_ack_out,
    output logic return_from_interrupt_out,
    // Bench control
    input wire logic stall_in,
    input wire logic ret_cmd_in
);
    // Quickest core: same-cycle ack unless stalled
    assign cpu_ack_out = irq_req_in & ~stall_in;
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            return_from_interrupt_out <= 1'b0;
        end else begin
            return_from_interrupt_out <= ret_cmd_in;
        end
    end
endmodule

// ### bench/prioritized_interrupt_controller_bench.sv
// Self-checking bench for the prioritized interrupt controller
`timescale 1ns/100ps
`include "irq_ctrl_consts.svh"
module prioritized_interrupt_controller_bench;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, err;
    logic [9:0] paddr = 10'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, irq_req, call_act, v_enter, irq_o, ack, ret;
    logic stall = 1'b1, ret_cmd = 1'b0, cmp_set = 1'b0, rtc_set = 1'b0, ce = 1'b1;
    logic [5:0] lv = 6'h00;
    logic [7:0] fa_set = 8'h00;
    logic [15:0] vec, vs;
    // Rows: index, write value, read-back value
    logic [23:0] regs [8] = '{24'hA8FFBF, 24'hB8FFBF, 24'h9AFF07, 24'hA9FF3F,
        24'hB9FF3F, 24'hC05A5A, 24'h97FF06, 24'h10FF00};
    logic [15:0] vecs [6] = '{16'h0003, 16'h0013, 16'h000B, 16'h001B, 16'h0023, 16'h0083};
    int bad_count = 0, cmp_count = 0, n, k, i, calls = 0, calls0;
    always #4 clk = ~clk;
    always @(negedge clk) if (call_act === 1'b1) calls++;
    irq_prio_ctrl u_dut (.ref_clk_in(clk), .arst_n_in(rst_n), .ce_in(ce),
        .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .pin_irq_a_in(lv[0]), .pin_irq_b_in(lv[1]), .timer0_req_in(lv[2]),
        .timer1_req_in(lv[3]), .serial_a_req_in(lv[4]), .serial_b_req_in(lv[5]),
        .flag_a_set_in(fa_set), .comparator_set_in(cmp_set), .clock_alarm_set_in(rtc_set),
        .cpu_ack_in(ack), .return_from_interrupt_in(ret), .irq_req_out(irq_req),
        .vector_out(vec), .call_active_out(call_act), .vector_enter_out(v_enter),
        .irq_out(irq_o));
    cpu_core_model u_core (.ref_clk_in(clk), .arst_n_in(rst_n), .irq_req_in(irq_req),
        .cpu_ack_out(ack), .return_from_interrupt_out(ret), .stall_in(stall),
        .ret_cmd_in(ret_cmd));
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (exp !== got) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    // Entered just after a rising edge; leaves one idle cycle behind
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        psel <= 1'b1;
        pwr <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
        if (n == 50) begin
            bad_count++;
            report_and_stop();
        end
    endtask
    // Waits for a request or a vector entry, sampled mid-cycle
    task automatic wait_on(input logic entry);
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while ((entry ? v_enter : irq_req) !== 1'b1 && k < 40);
        vs = vec;
        @(posedge clk);
        if (k == 40) begin
            bad_count++;
            report_and_stop();
        end
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (i = 0; i < 8; i++) begin
            apb(1'b0, regs[i][23:16], 8'h00);
            check("reset value", 0, rd);
            apb(1'b1, regs[i][23:16], regs[i][15:8]);
            apb(1'b0, regs[i][23:16], 8'h00);
            check("read back", regs[i][7:0], rd);
            if (i == 7) check("slave error", 1, err);
        end
        for (i = 0; i < 8; i++) apb(1'b1, regs[i][23:16], 8'h00);
        apb(1'b0, `IDX_FLAGS_B, 8'h00);
        check("flags b cleared", 0, rd);
        $display("register test done");
        apb(1'b1, `IDX_EN_A, 8'hBF);
        apb(1'b1, `IDX_EN_C, 8'h07);
        for (i = 0; i < 6; i++) begin
            lv <= 6'(1 << i);
            wait_on(1'b0);
            check("level source vector", vecs[i], vs);
            lv <= 6'h00;
            repeat (8) @(posedge clk);
        end
        $display("level source test done");
        apb(1'b1, `IDX_EN_A, 8'h3F);
        apb(1'b1, `IDX_EN_B, 8'hBF);
        fa_set <= 8'h05;
        cmp_set <= 1'b1;
        @(posedge clk);
        fa_set <= 8'h00;
        cmp_set <= 1'b0;
        repeat (6) @(negedge clk);
        check("gated request", 0, irq_req);
        @(posedge clk);
        apb(1'b0, `IDX_FLAGS_A, 8'h00);
        check("flags a", 8'h05, rd);
        apb(1'b1, `IDX_EN_A, 8'hBF);
        wait_on(1'b0);
        check("tie winner", 16'h0043, vs);
        apb(1'b1, `IDX_PRIO_LO, 8'h04);
        repeat (3) @(posedge clk);
        wait_on(1'b0);
        check("level one winner", 16'h0093, vs);
        apb(1'b1, `IDX_EVT_EN, 8'h01);
        stall <= 1'b0;
        wait_on(1'b1);
        stall <= 1'b1;
        check("entered vector", 16'h0093, vs);
        @(negedge clk);
        check("event interrupt", 1, irq_o);
        @(posedge clk);
        apb(1'b0, `IDX_FLAGS_B, 8'h00);
        check("flags b after entry", 0, rd);
        apb(1'b0, `IDX_FLAGS_A, 8'h00);
        check("flags a kept", 8'h05, rd);
        apb(1'b0, `IDX_INSERV, 8'h00);
        check("in service", 8'h02, rd);
        check("equal level held", 0, irq_req);
        apb(1'b1, `IDX_EVT_CLR, 8'h01);
        repeat (2) @(negedge clk);
        check("event cleared", 0, irq_o);
        @(posedge clk);
        apb(1'b1, `IDX_PRIO_HI, 8'h04);
        wait_on(1'b0);
        check("higher level preempts", 16'h0053, vs);
        apb(1'b1, `IDX_PRIO_HI, 8'h00);
        ret_cmd <= 1'b1;
        @(posedge clk);
        ret_cmd <= 1'b0;
        wait_on(1'b0);
        check("after return", 16'h0053, vs);
        apb(1'b1, `IDX_FLAGS_A, 8'h00);
        apb(1'b1, `IDX_PRIO_LO, 8'h00);
        $display("priority test done");
        calls0 = calls;
        stall <= 1'b0;
        rtc_set <= 1'b1;
        @(posedge clk);
        rtc_set <= 1'b0;
        wait_on(1'b1);
        // Set pulse and flag register add two cycles
        check("entry latency", 2 + 7, k);
        check("call cycles", 6, calls - calls0);
        check("alarm vector", 16'h008B, vs);
        $display("latency test done");
        apb(1'b1, `IDX_EN_B, 8'h3F);
        apb(1'b1, `IDX_PRIO_LO, 8'h20);
        fa_set <= 8'h80;
        @(posedge clk);
        fa_set <= 8'h00;
        repeat (2) @(negedge clk);
        check("reload without enable", 0, irq_req);
        @(posedge clk);
        apb(1'b1, `IDX_EN_B, 8'hBF);
        wait_on(1'b1);
        check("nested timer2 vector", 16'h002B, vs);
        apb(1'b0, `IDX_FLAGS_A, 8'h00);
        check("reload flag kept", 8'h80, rd);
        $display("timer2 test done");
        ce <= 1'b0;
        rtc_set <= 1'b1;
        @(negedge clk);
        check("frozen ready", 0, pready);
        @(posedge clk);
        ce <= 1'b1;
        rtc_set <= 1'b0;
        apb(1'b0, `IDX_FLAGS_B, 8'h00);
        check("frozen flags b", 0, rd);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check("irq after reset", 0, irq_o);
        apb(1'b0, `IDX_PRIO_LO, 8'h00);
        check("prio low after reset", 0, rd);
        $display("reset test done");
        report_and_stop();
    end
endmodule
